// ---- logic/vbc_band_cal.sv ----
`default_nettype none

// ==========================================================
// Oscillator core and band calibration sequencer.
module vbc_band_cal #(
    parameter int SETTLE_CYCLES = vbc_pkg::SETTLE_CYC
) (
    // Clock, reset and clock enable.
    input  wire logic                            mclk,
    input  wire logic                            nrst,
    input  wire logic                            clkEn,
    // Configuration from the serial port logic, same clock.
    input  wire logic                            freqWrite,
    input  wire vbc_pkg::vbc_cfg_s               cfg,
    input  wire vbc_pkg::vbc_num_s               num,
    // Comparator results from the analog side, asynchronous.
    input  wire vbc_pkg::vbc_meas_s              measRaw,
    // Oscillator control.
    output logic [vbc_pkg::CORE_W-1:0]           coreSel,
    output logic [vbc_pkg::BAND_W-1:0]           bandCode,
    output logic [vbc_pkg::NUM_W-1:0]            fracNum,
    // Calibration status.
    output vbc_pkg::vbc_stat_s                   status
);

    localparam int SETTLE_W = $clog2(SETTLE_CYCLES + 1);
    localparam logic [SETTLE_W-1:0] SETTLE_LOAD =
        SETTLE_W'(SETTLE_CYCLES - 1);
    localparam logic [SETTLE_W-1:0] SETTLE_ZERO = '0;
    localparam logic [SETTLE_W-1:0] SETTLE_DEC  = SETTLE_W'(1);

    // ==========================================================
    // State and working signals.
    vbc_pkg::vbc_state_e               state_reg;
    logic [SETTLE_W-1:0]               settle_reg;
    logic [vbc_pkg::CORE_W-1:0]        coreSel_reg;
    logic [vbc_pkg::BAND_W-1:0]        bandCode_reg;
    logic [vbc_pkg::NUM_W-1:0]         fracNum_reg;
    logic [vbc_pkg::CORE_COUNT-1:0]    visited_reg;
    logic                              dirDown_reg;
    logic                              done_reg;
    logic                              locked_reg;
    logic                              failed_reg;
    vbc_pkg::vbc_meas_s                meas;
    logic                              startCal;
    logic                              atLimit;
    logic                              enterSettle;
    logic                              nextOk;
    logic [vbc_pkg::CORE_W-1:0]        nextCore;
    logic [vbc_pkg::CORE_W-1:0]        startCore;
    logic                              judging;

    // ==========================================================
    // Comparator inputs cross into the clock domain here.
    vbc_sync #(
        .WIDTH ($bits(vbc_pkg::vbc_meas_s))
    ) u_meas_sync (
        .mclk  (mclk),
        .nrst  (nrst),
        .clkEn (clkEn),
        .d     (measRaw),
        .q     (meas)
    );

    // ==========================================================
    // Decisions.

    // A write with skip clear restarts the search even mid-run, so the newest word wins.
    assign startCal = freqWrite && !cfg.calSkip;
    assign judging  = (state_reg == vbc_pkg::ST_JUDGE) && !meas.locked;

    // Too fast means the code must rise, which lowers the frequency.
    assign atLimit = meas.fast ?
                     (bandCode_reg == vbc_pkg::BAND_MAX) :
                     (bandCode_reg == vbc_pkg::BAND_MIN);

    assign enterSettle = startCal ||
                         (judging && !atLimit) ||
                         ((state_reg == vbc_pkg::ST_SWITCH) && nextOk);

    // Starting core from the policy; core index 0 is the lowest band.
    always_comb begin
        unique case (cfg.policy)
            vbc_pkg::POLICY_AUTO:   startCore = vbc_pkg::CORE_FIRST;
            vbc_pkg::POLICY_SELECT: startCore = cfg.coreStart;
            vbc_pkg::POLICY_LAST:   startCore = coreSel_reg;
            default:                startCore = cfg.coreStart;
        endcase
    end

    // Neighbour core in the needed direction, never one already tried,
    // which stops the search from bouncing between two cores forever.
    always_comb begin
        nextOk   = 1'b0;
        nextCore = coreSel_reg;
        if (dirDown_reg) begin
            if (coreSel_reg != vbc_pkg::CORE_FIRST) begin
                nextCore = coreSel_reg - vbc_pkg::CORE_STEP;
                nextOk   = !visited_reg[nextCore];
            end
        end else begin
            if (coreSel_reg != vbc_pkg::CORE_TOP) begin
                nextCore = coreSel_reg + vbc_pkg::CORE_STEP;
                nextOk   = !visited_reg[nextCore];
            end
        end
    end

    // ==========================================================
    // Sequencer state.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= vbc_pkg::ST_IDLE;
        end else if (clkEn) begin
            if (startCal) begin
                state_reg <= vbc_pkg::ST_SETTLE;
            end else begin
                unique case (state_reg)
                    vbc_pkg::ST_IDLE: begin
                        state_reg <= vbc_pkg::ST_IDLE;
                    end
                    vbc_pkg::ST_SETTLE: begin
                        if (settle_reg == SETTLE_ZERO) begin
                            state_reg <= vbc_pkg::ST_JUDGE;
                        end
                    end
                    vbc_pkg::ST_JUDGE: begin
                        if (meas.locked) begin
                            state_reg <= vbc_pkg::ST_FINISH;
                        end else if (atLimit) begin
                            state_reg <= vbc_pkg::ST_SWITCH;
                        end else begin
                            state_reg <= vbc_pkg::ST_SETTLE;
                        end
                    end
                    vbc_pkg::ST_SWITCH: begin
                        if (nextOk) begin
                            state_reg <= vbc_pkg::ST_SETTLE;
                        end else begin
                            state_reg <= vbc_pkg::ST_FINISH;
                        end
                    end
                    vbc_pkg::ST_FINISH: begin
                        state_reg <= vbc_pkg::ST_IDLE;
                    end
                    default: begin
                        state_reg <= vbc_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Settling wait after every band or core change, covering the analog
    // response and the synchroniser delay before a judgement is trusted.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            settle_reg <= SETTLE_ZERO;
        end else if (clkEn) begin
            if (enterSettle) begin
                settle_reg <= SETTLE_LOAD;
            end else if ((state_reg == vbc_pkg::ST_SETTLE) &&
                         (settle_reg != SETTLE_ZERO)) begin
                settle_reg <= settle_reg - SETTLE_DEC;
            end
        end
    end

    // ==========================================================
    // Core select and band code; both hold outside a calibration.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            coreSel_reg  <= vbc_pkg::CORE_FIRST;
            bandCode_reg <= vbc_pkg::BAND_MIN;
        end else if (clkEn) begin
            if (startCal) begin
                coreSel_reg  <= startCore;
                bandCode_reg <= cfg.bandStart;
            end else if (judging && !atLimit) begin
                if (meas.fast) begin
                    bandCode_reg <= bandCode_reg + vbc_pkg::BAND_STEP;
                end else begin
                    bandCode_reg <= bandCode_reg - vbc_pkg::BAND_STEP;
                end
            end else if ((state_reg == vbc_pkg::ST_SWITCH) && nextOk) begin
                coreSel_reg  <= nextCore;
                bandCode_reg <= cfg.bandStart;
            end
        end
    end

    // Cores already tried, and which way the last failed search pointed.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            visited_reg <= '0;
            dirDown_reg <= 1'b0;
        end else if (clkEn) begin
            if (startCal) begin
                visited_reg            <= '0;
                visited_reg[startCore] <= 1'b1;
            end else if ((state_reg == vbc_pkg::ST_SWITCH) && nextOk) begin
                visited_reg[nextCore] <= 1'b1;
            end
            if (judging && atLimit) begin
                // Still fast at the lowest band: a lower core is needed.
                dirDown_reg <= meas.fast;
            end
        end
    end

    // ==========================================================
    // Numerator is captured on every frequency word write, skip or not.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fracNum_reg <= '0;
        end else if (clkEn && freqWrite) begin
            fracNum_reg <= {num.numUpper, num.numLower};
        end
    end

    // Result flags hold until the next start; done is one cycle wide.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            done_reg   <= 1'b0;
            locked_reg <= 1'b0;
            failed_reg <= 1'b0;
        end else if (clkEn) begin
            done_reg <= (state_reg == vbc_pkg::ST_FINISH) && !startCal;
            if (startCal) begin
                locked_reg <= 1'b0;
                failed_reg <= 1'b0;
            end else if ((state_reg == vbc_pkg::ST_JUDGE) && meas.locked) begin
                locked_reg <= 1'b1;
            end else if ((state_reg == vbc_pkg::ST_SWITCH) && !nextOk) begin
                failed_reg <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Outputs.
    assign coreSel  = coreSel_reg;
    assign bandCode = bandCode_reg;
    assign fracNum  = fracNum_reg;
    assign status   = {(state_reg != vbc_pkg::ST_IDLE), done_reg,
                       locked_reg, failed_reg};

    // ==========================================================
    // Checks.
    default clocking cbMain @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    sequence sStart;
        clkEn && startCal;
    endsequence

    sequence sNoCore;
        clkEn && !startCal && (state_reg == vbc_pkg::ST_SWITCH) && !nextOk;
    endsequence

    a_num_split: assert property (
        (clkEn && freqWrite) |=>
            (fracNum[vbc_pkg::NUM_W-1:vbc_pkg::NUM_LO_W] ==
             $past(num.numUpper)) &&
            (fracNum[vbc_pkg::NUM_LO_W-1:0] == $past(num.numLower)))
        else $error("Numerator fields not placed as upper and lower parts.");

    a_skip_blocks: assert property (
        (clkEn && freqWrite && cfg.calSkip && !status.busy) |=> !status.busy)
        else $error("Calibration started although skip was set.");

    a_start_select: assert property (
        (sStart and (cfg.policy == vbc_pkg::POLICY_SELECT)) |=>
            (coreSel == $past(cfg.coreStart)) && status.busy)
        else $error("Programmed start core not taken.");

    a_start_last: assert property (
        (sStart and (cfg.policy == vbc_pkg::POLICY_LAST)) |=>
            (coreSel == $past(coreSel)))
        else $error("Last-core policy changed the core at start.");

    a_start_band: assert property (
        sStart |=> (bandCode == $past(cfg.bandStart)) &&
                   (state_reg == vbc_pkg::ST_SETTLE))
        else $error("Search did not begin at the programmed band.");

    a_step_up: assert property (
        (clkEn && !startCal && judging && meas.fast && !atLimit) |=>
            (bandCode == $past(bandCode) + vbc_pkg::BAND_STEP))
        else $error("Fast oscillator did not raise the band code.");

    a_step_down: assert property (
        (clkEn && !startCal && judging && !meas.fast && !atLimit) |=>
            (bandCode == $past(bandCode) - vbc_pkg::BAND_STEP))
        else $error("Slow oscillator did not lower the band code.");

    a_limit_stop: assert property (
        (clkEn && !startCal && judging && atLimit) |=>
            (state_reg == vbc_pkg::ST_SWITCH) && $stable(bandCode))
        else $error("Band stepping went past a limit.");

    a_lock_done: assert property (
        (clkEn && !startCal && (state_reg == vbc_pkg::ST_JUDGE) &&
         meas.locked) ##1 (clkEn && !startCal) |=>
            status.done && status.locked)
        else $error("Lock did not end calibration with success.");

    a_no_core_end: assert property (
        sNoCore ##1 (clkEn && !startCal) |=>
            status.done && status.failed && !status.locked)
        else $error("Calibration did not end when no core was left.");

    a_hold_final: assert property (
        (clkEn && !startCal && (state_reg == vbc_pkg::ST_IDLE)) |=>
            $stable(coreSel) && $stable(bandCode))
        else $error("Final core or band changed while idle.");

    a_freeze_state: assert property (
        !clkEn |=> $stable(state_reg) && $stable(bandCode))
        else $error("State moved while clock enable was low.");

endmodule

`default_nettype wire

// ---- common/vbc_pkg.sv ----
// Contract
// - Fractional numerator is 22 bits: upper field bits 21..12, lower 11..0.
// - Four oscillator cores, each with 256 bands chosen by 8-bit band code.
// - Band code 255 is lowest frequency, 0 highest; higher code, lower freq.
// - A frequency change starts calibration at core picked by start policy.
// - The search inside the start core begins at the programmed band code.
// - Each step compares oscillator with target and moves band code toward it.
// - Stepping repeats until lock or the band code reaches 0 or 255.
// - No lock at a limit: move to next suitable core, else end calibration.
// - Policy 1 starts at programmed core; software should pick core 2.
// - A policy exists that starts at the core used by the last calibration.
// - Frequency word write starts calibration unless the skip bit is 1.
// - Core start select 0..3 maps lowest-frequency core to highest one.
`default_nettype none

package vbc_pkg;

    // ==========================================================
    // Oscillator geometry.
    localparam int CORE_COUNT = 4;
    localparam int CORE_W     = 2;
    localparam int BAND_W     = 8;
    localparam logic [CORE_W-1:0] CORE_FIRST = 2'h0;
    localparam logic [CORE_W-1:0] CORE_TOP   = 2'h3;
    localparam logic [CORE_W-1:0] CORE_STEP  = 2'h1;
    localparam logic [BAND_W-1:0] BAND_MIN   = 8'h00;
    localparam logic [BAND_W-1:0] BAND_MAX   = 8'hff;
    localparam logic [BAND_W-1:0] BAND_STEP  = 8'h01;

    // ==========================================================
    // Fractional numerator layout.
    localparam int NUM_HI_W = 10;
    localparam int NUM_LO_W = 12;
    localparam int NUM_W    = NUM_HI_W + NUM_LO_W;

    // ==========================================================
    // Start-core policy codes.
    localparam logic [1:0] POLICY_AUTO   = 2'h0;
    localparam logic [1:0] POLICY_SELECT = 2'h1;
    localparam logic [1:0] POLICY_LAST   = 2'h2;

    // ==========================================================
    // Timing.
    localparam int MCLK_PERIOD_NS = 100;
    localparam int SETTLE_NS      = 1000;
    localparam int SETTLE_CYC     =
        (SETTLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // ==========================================================
    // Types.
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SETTLE = 3'h1,
        ST_JUDGE  = 3'h3,
        ST_SWITCH = 3'h7,
        ST_FINISH = 3'h2  // One bit away from both judge and idle.
    } vbc_state_e;

    typedef struct packed {
        logic [1:0]        policy;
        logic [CORE_W-1:0] coreStart;
        logic [BAND_W-1:0] bandStart;
        logic              calSkip;
    } vbc_cfg_s;

    typedef struct packed {
        logic [NUM_HI_W-1:0] numUpper;
        logic [NUM_LO_W-1:0] numLower;
    } vbc_num_s;

    typedef struct packed {
        logic fast;
        logic locked;
    } vbc_meas_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic locked;
        logic failed;
    } vbc_stat_s;

endpackage

`default_nettype wire

// ---- logic/vbc_sync.sv ----
`default_nettype none

// ==========================================================
// Two-stage synchroniser for levels from outside the clock domain.
module vbc_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             nrst,
    input  wire logic             clkEn,
    // Data.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1_reg;
    logic [WIDTH-1:0] stage2_reg;

    // The first stage feeds only the second, so metastability stays here.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            stage1_reg <= '0;
            stage2_reg <= '0;
        end else if (clkEn) begin
            stage1_reg <= d;
            stage2_reg <= stage1_reg;
        end
    end

    assign q = stage2_reg;

endmodule

`default_nettype wire

// ---- verification/vbc_osc_model.sv ----
`default_nettype none

// ==========================================================
// Oscillator and comparator model standing behind the sequencer.
module vbc_osc_model (
    // Oscillator control from the sequencer.
    input  wire logic [vbc_pkg::CORE_W-1:0] coreSel,
    input  wire logic [vbc_pkg::BAND_W-1:0] bandCode,
    // Target frequency chosen by the bench.
    input  wire logic [vbc_pkg::CORE_W-1:0] tgtCore,
    input  wire logic [vbc_pkg::BAND_W-1:0] tgtBand,
    input  wire logic                       reachable,
    // Comparator results.
    output vbc_pkg::vbc_meas_s              meas
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [9:0] oscRank;
    logic [9:0] tgtRank;

    // A higher core runs faster, a higher band code runs slower.
    // The target lies above every band when it cannot be reached.
    always_comb begin
        oscRank     = {coreSel, ~bandCode};
        tgtRank     = {tgtCore, ~tgtBand};
        meas.fast   = reachable && (oscRank > tgtRank);
        meas.locked = reachable && (oscRank == tgtRank);
    end
endmodule

`default_nettype wire

// ---- verification/vbc_band_cal_tb.sv ----
`default_nettype none

// ==========================================================
// Self-checking bench for the band calibration sequencer.
module vbc_band_cal_tb;
    timeunit 1ns;
    timeprecision 1ns;

    localparam int SETTLE        = 4;
    localparam int CYCLE_CEILING = 20000;

    logic               mclk;
    logic               nrst;
    logic               clkEn;
    logic               freqWrite;
    vbc_pkg::vbc_cfg_s  cfg;
    vbc_pkg::vbc_num_s  num;
    vbc_pkg::vbc_meas_s measRaw;
    logic [1:0]         coreSel;
    logic [7:0]         bandCode;
    logic [21:0]        fracNum;
    vbc_pkg::vbc_stat_s status;
    logic [1:0]         tgtCore;
    logic [7:0]         tgtBand;
    logic               reachable;
    int                 n_mismatch;
    int                 check_count;
    int                 cycleCount = 0;

    // ==========================================================
    // Design and far-side model.
    vbc_band_cal #(.SETTLE_CYCLES(SETTLE)) dut (
        .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .freqWrite(freqWrite),
        .cfg(cfg), .num(num), .measRaw(measRaw), .coreSel(coreSel),
        .bandCode(bandCode), .fracNum(fracNum), .status(status)
    );

    vbc_osc_model osc (
        .coreSel(coreSel), .bandCode(bandCode), .tgtCore(tgtCore),
        .tgtBand(tgtBand), .reachable(reachable), .meas(measRaw)
    );

    // A 100 ns period clock.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // ==========================================================
    // Shared tasks.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One frequency word write; returns one and a half cycles after it was taken.
    task automatic start(input logic [1:0] pol, input logic [1:0] core,
                         input logic [7:0] band, input logic skip);
        @(negedge mclk);
        cfg.policy    = pol;
        cfg.coreStart = core;
        cfg.bandStart = band;
        cfg.calSkip   = skip;
        freqWrite     = 1'b1;
        @(negedge mclk);
        freqWrite = 1'b0;
        @(negedge mclk);
    endtask

    // Waits for the end-of-calibration pulse under a bound.
    task automatic wait_done(input int bound);
        int i;
        for (i = 0; i < bound && status.done !== 1'b1; i++) @(negedge mclk);
        check(32'(status.done), 32'h1);
    endtask

    task automatic expect_end(input logic [1:0] core, input logic [7:0] band,
                              input logic lock);
        check(32'(coreSel), 32'(core));
        check(32'(bandCode), 32'(band));
        check(32'(status.locked), 32'(lock));
        check(32'(status.failed), 32'(!lock));
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // A hang ends the run as a failure.
    always @(posedge mclk) begin
        cycleCount <= cycleCount + 1;
        if (cycleCount == CYCLE_CEILING) begin
            n_mismatch++;
            complete_run();
        end
    end

    // ==========================================================
    // Main sequence.
    initial begin
        n_mismatch  = 0;
        check_count = 0;
        nrst        = 1'b0;
        clkEn       = 1'b1;
        freqWrite   = 1'b0;
        cfg         = '0;
        num         = '0;
        tgtCore     = 2'h2;
        tgtBand     = 8'h43;
        reachable   = 1'b1;
        repeat (20) @(negedge mclk);
        check(32'(fracNum), 32'h0);
        check(32'(status), 32'h0);
        nrst = 1'b1;

        // A skipped write only loads the numerator, upper field on top.
        num = '{numUpper: 10'h2a5, numLower: 12'hb3c};
        start(2'h1, 2'h2, 8'h40, 1'b1);
        check(32'(fracNum), 32'h002a5b3c);
        check(32'(status.busy), 32'h0);
        check(32'(coreSel), 32'h0);

        // Programmed core and band, stepping up the code to a slower band.
        start(2'h1, 2'h2, 8'h40, 1'b0);
        check(32'(coreSel), 32'h2);
        check(32'(bandCode), 32'h40);
        check(32'(status.busy), 32'h1);
        // Clock enable low freezes the search while it settles.
        clkEn = 1'b0;
        repeat (10) @(negedge mclk);
        check(32'(bandCode), 32'h40);
        check(32'(status.busy), 32'h1);
        clkEn = 1'b1;
        wait_done(200);
        expect_end(2'h2, 8'h43, 1'b1);
        @(negedge mclk);
        check(32'(status.done), 32'h0);
        check(32'(status.busy), 32'h0);
        repeat (20) @(negedge mclk);
        expect_end(2'h2, 8'h43, 1'b1);

        // Last-core policy ignores the programmed core; code steps down.
        tgtBand = 8'h3d;
        start(2'h2, 2'h0, 8'h40, 1'b0);
        check(32'(coreSel), 32'h2);
        wait_done(200);
        expect_end(2'h2, 8'h3d, 1'b1);

        // Code limit without lock moves down a core, then finds lock.
        // Here the top core is not the start core, as a deep jump may follow.
        tgtCore = 2'h1;
        tgtBand = 8'h10;
        start(2'h1, 2'h2, 8'hfe, 1'b0);
        wait_done(3000);
        expect_end(2'h1, 8'h10, 1'b1);

        // Unreachable target: policy 0 starts low, climbs all cores, fails.
        reachable = 1'b0;
        start(2'h0, 2'h2, 8'h02, 1'b0);
        check(32'(coreSel), 32'h0);
        check(32'(bandCode), 32'h02);
        wait_done(500);
        expect_end(2'h3, 8'h00, 1'b0);

        // Back-to-back starts over every core; the newest one wins.
        reachable = 1'b1;
        tgtCore   = 2'h2;
        tgtBand   = 8'h80;
        for (int c = 0; c < 4; c++) begin
            // Policy 3 behaves as policy 1 and takes the programmed core.
            start(c[0] ? 2'h3 : 2'h1, 2'(c), 8'h80, 1'b0);
            check(32'(coreSel), 32'(c));
        end
        wait_done(2000);
        expect_end(2'h2, 8'h80, 1'b1);
        complete_run();
    end
endmodule

`default_nettype wire
